// ---- fmac_pkg.sv ----
package fmac_pkg;
   // register offsets
   localparam logic [7:0] FAULT_MASK_ADDR = 8'h14;
   localparam logic [7:0] ADC_CTRL_ADDR = 8'h15;
   localparam logic [7:0] CHAN_DIS_ADDR = 8'h16;
   // reset values
   localparam logic [7:0] FAULT_MASK_RST = 8'h00;
   localparam logic [7:0] ADC_CTRL_RST = 8'h30;
   localparam logic [7:0] CHAN_DIS_RST = 8'h00;
   // writable bits
   localparam logic [7:0] FAULT_MASK_WMASK = 8'hD8;
   localparam logic [7:0] ADC_CTRL_WMASK = 8'hF0;
   localparam logic [7:0] CHAN_DIS_WMASK = 8'hF7;
   // field positions
   localparam int OVP_BIT = 7;
   localparam int THERMAL_SHUTDOWN_FAULT_BIT = 6;
   localparam int TMR_BIT = 4;
   localparam int SNS_BIT = 3;
   localparam int ADC_EN_BIT = 7;
   localparam int ADC_RATE_BIT = 6;
   localparam int ADC_SAMPLE_LSB = 4;
   // cycles per channel conversion, per resolution code
   localparam logic [15:0] CONV_CYC_15B = 16'h0040;
   localparam logic [15:0] CONV_CYC_14B = 16'h0020;
   localparam logic [15:0] CONV_CYC_13B = 16'h0010;
   localparam logic [15:0] CONV_CYC_12B = 16'h0008;
   localparam int NUM_CHAN = 8;

   typedef struct packed {
      logic input_overvoltage_fault;
      logic thermal_shutdown_fault;
      logic safety_timer_fault;
      logic sense_short_fault;
   } fmac_faults_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fmac_req_s;
endpackage

// ---- fmac_edge.sv ----
`timescale 1ns/10ps
module fmac_edge #(
   parameter int WIDTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic reg_rst_i,
   // levels in, rising pulses out
   input wire logic [WIDTH-1:0] level_i,
   output logic [WIDTH-1:0] rise_o
);
   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] next_prev;
   logic [WIDTH-1:0] next_rise;

   // refuse an empty level vector
   if (WIDTH < 1) begin : g_width_check
      $error("fmac_edge needs at least one level");
   end

   always_comb begin
      next_prev = level_i;
      next_rise = reg_rst_i ? '0 : (level_i & ~prev);
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev <= '0;
         rise_o <= '0;
      end else begin
         prev <= next_prev;
         rise_o <= next_rise;
      end
   end
endmodule

// ---- fmac_regs.sv ----
`timescale 1ns/10ps
module fmac_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // resets from the device
   input wire logic reg_rst_i,
   input wire logic watchdog_expire_i,
   // register access port
   input wire fmac_pkg::fmac_req_s req_i,
   output logic [7:0] rdata_o,
   // fault levels and other mask
   input wire fmac_pkg::fmac_faults_s faults_i,
   input wire logic adc_done_irq_mask_i,
   // adc controls out
   output logic adc_enable_o,
   output logic adc_one_shot_o,
   output logic [1:0] adc_sample_o,
   output logic [7:0] adc_channel_disable_o,
   output logic [2:0] adc_channel_o,
   output logic adc_convert_o,
   output logic adc_done_o,
   // flags and interrupt
   output logic [2:0] fault_flags_o,
   output logic int_pulse_o
);
   logic [7:0] fault_interrupt_mask;
   logic [7:0] adc_control;
   logic [7:0] adc_channel_disable;
   logic [2:0] flags;
   logic [2:0] chan;
   logic [15:0] cyc;
   logic [7:0] next_fault_interrupt_mask;
   logic [7:0] next_adc_control;
   logic [7:0] next_adc_channel_disable;
   logic [2:0] next_flags;
   logic [2:0] next_chan;
   logic [15:0] next_cyc;
   logic [7:0] next_rdata;
   logic next_int;
   logic next_done;
   logic [3:0] rise;
   logic [15:0] conv_len;
   logic chan_last;
   logic done_ev;
   logic [2:0] next_chan_idx;
   logic found;
   logic convert;
   logic next_convert;

   fmac_edge #(.WIDTH(4)) u_edge (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .reg_rst_i(reg_rst_i),
      .level_i(faults_i),
      .rise_o(rise)
   );

   always_comb begin
      unique case (adc_control[5:4])
         2'b00: conv_len = fmac_pkg::CONV_CYC_15B;
         2'b01: conv_len = fmac_pkg::CONV_CYC_14B;
         2'b10: conv_len = fmac_pkg::CONV_CYC_13B;
         2'b11: conv_len = fmac_pkg::CONV_CYC_12B;
      endcase
      found = 1'b0;
      next_chan_idx = chan;
      for (int i = fmac_pkg::NUM_CHAN - 1; i >= 0; i--) begin
         if (!found && i < int'(chan) && !adc_channel_disable[i]
            && fmac_pkg::CHAN_DIS_WMASK[i]) begin
            found = 1'b1;
            next_chan_idx = 3'(i);
         end
      end
      chan_last = !found;
   end

   always_comb begin
      next_fault_interrupt_mask = fault_interrupt_mask;
      next_adc_control = adc_control;
      next_adc_channel_disable = adc_channel_disable;
      next_flags = flags;
      next_chan = chan;
      next_cyc = cyc;
      next_done = 1'b0;
      done_ev = 1'b0;
      if (adc_control[fmac_pkg::ADC_EN_BIT]) begin
         if (cyc + 16'h0001 >= conv_len) begin
            next_cyc = '0;
            if (chan_last) begin
               next_chan = 3'h7;
               if (adc_control[fmac_pkg::ADC_RATE_BIT]) begin
                  next_adc_control[fmac_pkg::ADC_EN_BIT] = 1'b0;
                  done_ev = 1'b1;
                  next_done = 1'b1;
               end
            end else begin
               next_chan = next_chan_idx;
            end
         end else begin
            next_cyc = cyc + 16'h0001;
         end
      end else begin
         next_cyc = '0;
         next_chan = 3'h7;
      end
      next_flags = flags | {rise[3], rise[2], rise[1]};
      if (req_i.wr) begin
         unique case (req_i.addr)
            fmac_pkg::FAULT_MASK_ADDR: next_fault_interrupt_mask =
               req_i.wdata & fmac_pkg::FAULT_MASK_WMASK;
            fmac_pkg::ADC_CTRL_ADDR: next_adc_control =
               req_i.wdata & fmac_pkg::ADC_CTRL_WMASK;
            fmac_pkg::CHAN_DIS_ADDR: next_adc_channel_disable =
               req_i.wdata & fmac_pkg::CHAN_DIS_WMASK;
            default: ;
         endcase
      end
      if (watchdog_expire_i) begin
         next_adc_control[fmac_pkg::ADC_EN_BIT] = 1'b0;
      end
      if (reg_rst_i) begin
         next_fault_interrupt_mask = fmac_pkg::FAULT_MASK_RST;
         next_adc_control = fmac_pkg::ADC_CTRL_RST;
         next_adc_channel_disable = fmac_pkg::CHAN_DIS_RST;
         next_flags = '0;
         next_chan = 3'h7;
         next_cyc = '0;
         done_ev = 1'b0;
         next_done = 1'b0;
      end
      next_convert = next_adc_control[fmac_pkg::ADC_EN_BIT]
         & ~next_adc_channel_disable[next_chan];
      next_int = rise[3] & ~fault_interrupt_mask[fmac_pkg::OVP_BIT];
      next_int = next_int
         | (rise[2] & ~fault_interrupt_mask[fmac_pkg::THERMAL_SHUTDOWN_FAULT_BIT]);
      next_int = next_int
         | (rise[1] & ~fault_interrupt_mask[fmac_pkg::TMR_BIT]);
      next_int = next_int
         | (rise[0] & ~fault_interrupt_mask[fmac_pkg::SNS_BIT]);
      next_int = next_int | (done_ev & ~adc_done_irq_mask_i);
      next_rdata = 8'h00;
      if (req_i.rd) begin
         unique case (req_i.addr)
            fmac_pkg::FAULT_MASK_ADDR: next_rdata = fault_interrupt_mask;
            fmac_pkg::ADC_CTRL_ADDR: next_rdata = adc_control;
            fmac_pkg::CHAN_DIS_ADDR: next_rdata = adc_channel_disable;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fault_interrupt_mask <= fmac_pkg::FAULT_MASK_RST;
         adc_control <= fmac_pkg::ADC_CTRL_RST;
         adc_channel_disable <= fmac_pkg::CHAN_DIS_RST;
         flags <= '0;
         chan <= 3'h7;
         cyc <= '0;
         rdata_o <= 8'h00;
         int_pulse_o <= 1'b0;
         adc_done_o <= 1'b0;
         convert <= 1'b0;
      end else begin
         fault_interrupt_mask <= next_fault_interrupt_mask;
         adc_control <= next_adc_control;
         adc_channel_disable <= next_adc_channel_disable;
         flags <= next_flags;
         chan <= next_chan;
         cyc <= next_cyc;
         rdata_o <= next_rdata;
         int_pulse_o <= next_int;
         adc_done_o <= next_done;
         convert <= next_convert;
      end
   end

   // outputs straight from state
   assign adc_enable_o = adc_control[fmac_pkg::ADC_EN_BIT];
   assign adc_one_shot_o = adc_control[fmac_pkg::ADC_RATE_BIT];
   assign adc_sample_o = adc_control[5:4];
   assign adc_channel_disable_o = adc_channel_disable;
   assign adc_channel_o = chan;
   assign adc_convert_o = convert;
   assign fault_flags_o = flags;
endmodule

// ---- fmac_regs_monitor.sv ----
`timescale 1ns/10ps
module fmac_regs_monitor (
   // watched ports
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic reg_rst_i,
   input wire logic watchdog_expire_i,
   input wire fmac_pkg::fmac_req_s req_i,
   input wire logic [7:0] rdata_o,
   input wire fmac_pkg::fmac_faults_s faults_i,
   input wire logic adc_done_irq_mask_i,
   input wire logic adc_enable_o,
   input wire logic adc_one_shot_o,
   input wire logic [1:0] adc_sample_o,
   input wire logic [7:0] adc_channel_disable_o,
   input wire logic [2:0] adc_channel_o,
   input wire logic adc_convert_o,
   input wire logic adc_done_o,
   input wire logic [2:0] fault_flags_o,
   input wire logic int_pulse_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic hit;
   assign hit = req_i.addr inside {8'h14, 8'h15, 8'h16};
   AST_IDLE_READ:
   assert property (!(req_i.rd && hit) |=> rdata_o == 8'h00)
      else $error("stray read");
   AST_CTRL_READ:
   assert property (req_i.rd && req_i.addr == 8'h15 |=> rdata_o ==
      {$past(adc_enable_o), $past(adc_one_shot_o), $past(adc_sample_o), 4'h0})
      else $error("ctrl read");
   AST_DIS_READ:
   assert property (req_i.rd && req_i.addr == 8'h16 |=>
      rdata_o == $past(adc_channel_disable_o) && !rdata_o[3])
      else $error("dis read");
   AST_CTRL_WRITE:
   assert property (req_i.wr && req_i.addr == 8'h15 && !reg_rst_i |=>
      {adc_one_shot_o, adc_sample_o} == $past(req_i.wdata[6:4]))
      else $error("ctrl write");
   AST_WDOG:
   assert property (watchdog_expire_i && !reg_rst_i && !req_i.wr |=>
      !adc_enable_o && $stable({adc_one_shot_o, adc_sample_o}))
      else $error("wdog");
   AST_REG_RST:
   assert property (reg_rst_i |=> fault_flags_o == 3'h0 && !adc_enable_o
      && adc_sample_o == 2'h3 && adc_channel_disable_o == 8'h00)
      else $error("reg reset");
   AST_FLAG_SET:
   assert property ($rose(faults_i.thermal_shutdown_fault) && !reg_rst_i
      |-> ##[1:3] fault_flags_o[1]) else $error("flag set");
   AST_FLAG_HOLD:
   assert property (fault_flags_o[2] && !reg_rst_i |=> fault_flags_o[2])
      else $error("flag hold");
   AST_NO_RESERVED_CHAN:
   assert property (adc_enable_o |-> adc_channel_o != 3'h3)
      else $error("reserved channel");
   AST_CONVERT_GATE:
   assert property (adc_convert_o == (adc_enable_o
      && !adc_channel_disable_o[adc_channel_o]))
      else $error("convert gate");
   AST_DONE_IRQ:
   assert property (adc_done_o && !$past(adc_done_irq_mask_i) |->
      int_pulse_o) else $error("done irq");
   cover property (adc_done_o && int_pulse_o);
   cover property (adc_convert_o ##1 !adc_convert_o);
   cover property (watchdog_expire_i ##1 !adc_enable_o);
   cover property ($rose(fault_flags_o[0]));
   cover property (reg_rst_i);
endmodule
bind fmac_regs fmac_regs_monitor mon_u (.*);

// ---- fmac_host.sv ----
`timescale 1ns/10ps
module fmac_host (
   // clock
   input wire logic clk_i,
   // register port
   output fmac_pkg::fmac_req_s req_o,
   input wire logic [7:0] rdata_i
);
   initial req_o = '0;
   task access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clk_i);
      req_o <= {w, ~w, a, d};
      @(posedge clk_i);
      req_o <= {2'b00, ~a, ~d};
      @(posedge clk_i);
      q = rdata_i;
   endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps
`define CHK(g, e) check(8'(g), 8'(e))
module testbench;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic rrst = 1'b0;
   logic wdog = 1'b0;
   logic dmask = 1'b0;
   fmac_pkg::fmac_faults_s flt = '0;
   fmac_pkg::fmac_req_s req;
   logic [7:0] rdata, q, m;
   logic en, done, irq;
   logic [2:0] flags;
   logic [2:0] chan;
   logic f;
   int failures = 0;
   int total_checks = 0;
   integer seed = 32'hE0F8;
   int d, p, t, l;
   always #2 clk_i = ~clk_i;
   fmac_regs dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .reg_rst_i(rrst),
      .watchdog_expire_i(wdog), .req_i(req), .rdata_o(rdata),
      .faults_i(flt), .adc_done_irq_mask_i(dmask), .adc_enable_o(en),
      .adc_one_shot_o(), .adc_sample_o(), .adc_channel_disable_o(),
      .adc_channel_o(chan), .adc_convert_o(), .adc_done_o(done),
      .fault_flags_o(flags), .int_pulse_o(irq));
   fmac_host host_u (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));
   task check(input logic [7:0] g, e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t %h %h", $time, g, e);
      end
   endtask
   function logic [7:0] wmask(input logic [7:0] a);
      return a == 8'h14 ? 8'hD8 : a == 8'h15 ? 8'hF0 : 8'hF7;
   endfunction
   function int slot_len(input int s);
      return int'(s == 0 ? fmac_pkg::CONV_CYC_15B : s == 1 ?
         fmac_pkg::CONV_CYC_14B : s == 2 ? fmac_pkg::CONV_CYC_13B :
         fmac_pkg::CONV_CYC_12B);
   endfunction
   task wr(input logic [7:0] a, v);
      host_u.access(1'b1, a, v, q);
   endtask
   task rdc(input logic [7:0] a, e);
      host_u.access(1'b0, a, 8'h00, q);
      `CHK(q, e);
   endtask
   task strobe(input logic w);
      @(posedge clk_i) {wdog, rrst} <= {w, ~w};
      @(posedge clk_i) {wdog, rrst} <= 2'b00;
   endtask
   task watch(input int n);
      d = 0;
      p = 0;
      t = 0;
      l = 0;
      f = 1'b0;
      for (int j = 1; j <= n; j++) begin
         @(posedge clk_i);
         d += done;
         p += irq;
         if (done) t = j;
         if (chan == 3'h5) f = 1'b1;
         if (chan == 3'h6 && !f) l++;
      end
   endtask
   task conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rstn_i <= 1'b1;
      rdc(8'h14, 8'h00);
      rdc(8'h15, 8'h30);
      rdc(8'h16, 8'h00);
      rdc(8'h13, 8'h00);
      for (int a = 8'h14; a < 8'h17; a++) begin
         wr(8'(a), 8'hFF);
         rdc(8'(a), wmask(8'(a)));
      end
      strobe(1'b1);
      rdc(8'h15, 8'h70);
      rdc(8'h14, 8'hD8);
      strobe(1'b0);
      rdc(8'h15, 8'h30);
      rdc(8'h16, 8'h00);
      for (int r = 0; r < 6; r++) begin
         m = 8'($random(seed));
         wr(8'h14, m);
         for (int i = 0; i < 4; i++) begin
            @(posedge clk_i) flt <= 4'(4'h8 >> i);
            watch(5);
            `CHK(p, !m[i < 2 ? 7 - i : 6 - i]);
            @(posedge clk_i) flt <= '0;
         end
      end
      `CHK(flags, 3'h7);
      wr(8'h14, 8'h00);
      @(posedge clk_i) flt <= 4'hF;
      watch(5);
      `CHK(p, 1);
      @(posedge clk_i) flt <= '0;
      strobe(1'b0);
      @(posedge clk_i);
      `CHK(flags, 3'h0);
      for (int k = 0; k < 2; k++) begin
         dmask <= 1'(k);
         m = 8'($random(seed)) & 8'hF7;
         wr(8'h16, m);
         wr(8'h15, 8'hF0);
         watch(150);
         `CHK(d, 1);
         `CHK(t, (1 + $countones(~m & 8'h77)) * slot_len(3));
         `CHK(en, 1'b0);
         `CHK(p, k == 0);
         rdc(8'h15, 8'h70);
      end
      wr(8'h16, 8'h00);
      for (int s = 0; s < 4; s++) begin
         strobe(1'b1);
         wr(8'h15, 8'(8'h80 | s << 4));
         watch(150);
         `CHK(d, 0);
         `CHK(l, slot_len(s));
         rdc(8'h15, 8'(8'h80 | s << 4));
      end
      conclude();
   end
endmodule
